// ==== include/pwm_pkg.sv ====
package pwm_pkg;
	// ----------------------------------------
	// Bus and data widths
	// ----------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int SUB_W = 2;
	localparam int DUTY_W = 10;
	localparam int TIMER_N = 3;
	localparam int STAT_W = 4;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_DUTY_WRITE = 5'h01;
	localparam logic [4:0] OFS_DUTY_ACTIVE = 5'h02;
	localparam logic [4:0] OFS_TIMER_SELECT = 5'h03;
	localparam logic [4:0] OFS_PIN_DIR = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h05;
	localparam logic [4:0] OFS_MASK = 5'h06;
	localparam logic [4:0] OFS_TIMER_BASE = 5'h08;
	localparam logic [4:0] OFS_TIMER_LAST = 5'h13;
	localparam logic [1:0] TREG_CONTROL = 2'h0;
	localparam logic [1:0] TREG_PERIOD = 2'h1;
	localparam logic [1:0] TREG_COUNT = 2'h2;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_LOW_LSB = 4;
	localparam int CTRL_MODE_LSB = 2;
	localparam logic [1:0] PWM_MODE_CODE = 2'h3;
	localparam int TCTRL_RUN_BIT = 2;
	localparam int TCTRL_POST_LSB = 3;
	localparam int TCTRL_W = 7;
	localparam int STAT_PERIOD_BIT = 3;
	// ----------------------------------------
	// Reset values and prescale codes
	// ----------------------------------------
	localparam logic [7:0] PERIOD_RESET = 8'hFF;
	localparam logic PIN_DIR_RESET = 1'b1;
	localparam logic [1:0] PRESCALE_1 = 2'h0;
	localparam logic [1:0] PRESCALE_4 = 2'h1;
	localparam logic [4:0] DIV_1 = 5'h01;
	localparam logic [4:0] DIV_4 = 5'h04;
	localparam logic [4:0] DIV_16 = 5'h10;

	function automatic logic [4:0] prescale_div(input logic [1:0] code);
		if (code == PRESCALE_1) begin
			return DIV_1;
		end else if (code == PRESCALE_4) begin
			return DIV_4;
		end
		return DIV_16;
	endfunction : prescale_div
endpackage : pwm_pkg

// ==== include/timer_if.sv ====
`timescale 1ns/10ps
interface timer_if;
	logic run;
	logic [1:0] prescale_sel;
	logic [3:0] postscale;
	logic [7:0] period;
	logic load;
	logic [7:0] load_value;
	logic [7:0] count;
	logic [1:0] sub;
	logic restart;
	logic flag;
	logic step;
	modport owner(output run, prescale_sel, postscale, period, load, load_value,
		input count, sub, restart, flag, step);
	modport counter(input run, prescale_sel, postscale, period, load, load_value,
		output count, sub, restart, flag, step);
endinterface : timer_if

// ==== logic/pwm_timer.sv ====
`timescale 1ns/10ps
module pwm_timer import pwm_pkg::*; (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	timer_if.counter timer_bus
);
	logic [3:0] div;
	logic [1:0] sub;
	logic [7:0] count;
	logic [3:0] post_cnt;
	logic [4:0] div_max;
	logic step;
	logic inc;
	logic wrap;

	// ----------------------------------------
	// Prescaler and two-bit phase
	// ----------------------------------------
	assign div_max = prescale_div(timer_bus.prescale_sel) - 5'h01;
	assign step = timer_bus.run && (div == div_max[3:0]);
	assign inc = step && (sub == 2'h3);
	assign wrap = inc && (count == timer_bus.period);

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div <= 4'h0;
		end else if (!timer_bus.run || step) begin
			div <= 4'h0;
		end else begin
			div <= div + 4'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sub <= 2'h0;
		end else if (timer_bus.load) begin
			sub <= 2'h0;
		end else if (step) begin
			sub <= sub + 2'h1; // [RL3]
		end
	end

	// ----------------------------------------
	// Count and period wrap
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= 8'h00;
		end else if (timer_bus.load) begin
			count <= timer_bus.load_value;
		end else if (wrap) begin
			count <= 8'h00; // [RL4]
		end else if (inc) begin
			count <= count + 8'h01;
		end
	end

	// Postscaler only paces the flag
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			post_cnt <= 4'h0;
		end else if (wrap) begin
			post_cnt <= (post_cnt == timer_bus.postscale) ? 4'h0 : post_cnt + 4'h1; // [RL7]
		end
	end

	assign timer_bus.count = count;
	assign timer_bus.sub = sub;
	assign timer_bus.restart = wrap;
	// Time base advances at the next edge
	assign timer_bus.step = step;
	assign timer_bus.flag = wrap && (post_cnt == timer_bus.postscale);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_count_wrap_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL4]
		wrap && !timer_bus.load |=> count == 8'h00 && sub == 2'h0)
		else $error("timer did not clear after period match");
	a_postscale_free: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL7]
		timer_bus.flag |-> wrap)
		else $error("timer flag outside a period wrap");
	a_count_paced: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL3]
		!inc && !timer_bus.load |=> $stable(count))
		else $error("timer count moved without increment");
endmodule : pwm_timer

// ==== logic/standard_pwm_channel.sv ====
`timescale 1ns/10ps
// Overview of operation
// [RL1] One output pin carries a PWM waveform with up to ten bits of duty.
// [RL2] A two-bit select picks one of three eight-bit timers as time base.
// [RL3] Period is (period_limit+1) times four oscillator periods times the prescale.
// [RL4] When count equals period_limit, the next increment clears the count.
// [RL5] That increment sets the pin high, unless the duty value is zero.
// [RL6] That increment copies the written duty byte into the active buffer.
// [RL7] The timer postscaler never affects PWM period or frequency.
// [RL8] Duty is ten bits: written byte on top, control bits 5:4 below.
// [RL9] Duty writes are taken any time but act only from the next period.
// [RL10] In PWM mode the active duty buffer ignores software writes.
// [RL11] High time is duty value times oscillator period times prescale.
// [RL12] Count plus two phase bits form a time base; a match clears the pin.
// [RL13] The two low duty bits are double buffered beside the active buffer.
// [RL14] Writing zero to the control register releases the pin.
// [RL15] Software clears the pin direction bit to let the waveform out.
// [RL16] Software sets up timer, period, mode and duty before enabling the driver.
// [RL17] Waiting for a first full period is optional for software.
// [RL18] After reset the pin is low, duty buffers zero, PWM mode off.
module standard_pwm_channel import pwm_pkg::*; (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	output logic pwm_output_pin_out,
	output logic pwm_output_pin_oe_out,
	output logic irq_out
);
	// ----------------------------------------
	// Software visible state
	// ----------------------------------------
	logic [7:0] channel_control_register;
	logic [7:0] duty_write_byte;
	logic [7:0] duty_active_buffer;
	logic [1:0] duty_latch;
	logic [1:0] timer_source_select;
	logic pin_direction_bit;
	logic [STAT_W-1:0] status;
	logic [STAT_W-1:0] mask;
	logic [TCTRL_W-1:0] timer_control_register [TIMER_N];
	logic [7:0] period_limit [TIMER_N];

	// ----------------------------------------
	// Timer bank
	// ----------------------------------------
	timer_if timer_bus [TIMER_N] ();
	logic [7:0] tmr_count [TIMER_N];
	logic [1:0] tmr_sub [TIMER_N];
	logic [TIMER_N-1:0] tmr_restart;
	logic [TIMER_N-1:0] tmr_flag;
	logic [TIMER_N-1:0] tmr_step;

	logic write_hit_timer;
	logic [1:0] timer_index;
	logic [1:0] timer_field;
	logic [4:0] timer_offset;

	assign timer_offset = reg_addr_in - OFS_TIMER_BASE;
	assign timer_index = timer_offset[3:2];
	assign timer_field = timer_offset[1:0];
	assign write_hit_timer = reg_write_in && in_timer_window(reg_addr_in);

	function automatic logic in_timer_window(input logic [ADDR_W-1:0] addr);
		return (addr >= OFS_TIMER_BASE) && (addr <= OFS_TIMER_LAST);
	endfunction : in_timer_window

	// Three selects, code three falls back to the first timer
	function automatic logic [1:0] source_index(input logic [1:0] code);
		return (code < 2'(TIMER_N)) ? code : 2'h0;
	endfunction : source_index

	genvar g;
	generate
		for (g = 0; g < TIMER_N; g++) begin : gen_timer
			pwm_timer u_timer (
				.mclk_in(mclk_in),
				.reset_n_in(reset_n_in),
				.timer_bus(timer_bus[g])
			);
			assign timer_bus[g].run = timer_control_register[g][TCTRL_RUN_BIT];
			assign timer_bus[g].prescale_sel = timer_control_register[g][1:0];
			assign timer_bus[g].postscale = timer_control_register[g][TCTRL_W-1:TCTRL_POST_LSB];
			assign timer_bus[g].period = period_limit[g];
			assign timer_bus[g].load = write_hit_timer && timer_index == 2'(g) && timer_field == TREG_COUNT;
			assign timer_bus[g].load_value = reg_wdata_in;
			assign tmr_count[g] = timer_bus[g].count;
			assign tmr_sub[g] = timer_bus[g].sub;
			assign tmr_restart[g] = timer_bus[g].restart;
			assign tmr_flag[g] = timer_bus[g].flag;
			assign tmr_step[g] = timer_bus[g].step;
		end
	endgenerate

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < TIMER_N; i++) begin
				timer_control_register[i] <= '0;
				period_limit[i] <= PERIOD_RESET;
			end
		end else if (write_hit_timer) begin
			for (int i = 0; i < TIMER_N; i++) begin
				if (timer_index == 2'(i) && timer_field == TREG_CONTROL) begin
					timer_control_register[i] <= reg_wdata_in[TCTRL_W-1:0];
				end else if (timer_index == 2'(i) && timer_field == TREG_PERIOD) begin
					period_limit[i] <= reg_wdata_in;
				end
			end
		end
	end

	// ----------------------------------------
	// Selected time base
	// ----------------------------------------
	logic [1:0] sel;
	logic sel_restart;
	logic sel_step;
	logic [DUTY_W-1:0] time_base;
	logic [DUTY_W-1:0] base_ahead;
	logic [DUTY_W-1:0] duty_now;
	logic [DUTY_W-1:0] duty_next;
	logic pwm_active;

	assign sel = source_index(timer_source_select); // [RL2]
	assign sel_restart = tmr_restart[sel];
	assign sel_step = tmr_step[sel];
	assign time_base = {tmr_count[sel], tmr_sub[sel]}; // [RL12]
	// Registered pin must fall on the edge the time base reaches the duty
	assign base_ahead = time_base + 10'h001;
	assign duty_now = {duty_active_buffer, duty_latch}; // [RL1]
	assign duty_next = {duty_write_byte, channel_control_register[CTRL_LOW_LSB+:2]}; // [RL8]
	assign pwm_active = channel_control_register[CTRL_MODE_LSB+:2] == PWM_MODE_CODE;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			channel_control_register <= 8'h00; // [RL18]
			duty_write_byte <= 8'h00;
			timer_source_select <= 2'h0;
			pin_direction_bit <= PIN_DIR_RESET;
			mask <= '0;
		end else if (reg_write_in) begin
			if (reg_addr_in == OFS_CONTROL) begin
				channel_control_register <= reg_wdata_in; // [RL9]
			end else if (reg_addr_in == OFS_DUTY_WRITE) begin
				duty_write_byte <= reg_wdata_in; // [RL9]
			end else if (reg_addr_in == OFS_TIMER_SELECT) begin
				timer_source_select <= reg_wdata_in[1:0];
			end else if (reg_addr_in == OFS_PIN_DIR) begin
				pin_direction_bit <= reg_wdata_in[0];
			end else if (reg_addr_in == OFS_MASK) begin
				mask <= reg_wdata_in[STAT_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Duty double buffer
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			duty_active_buffer <= 8'h00; // [RL18]
			duty_latch <= 2'h0;
		end else if (pwm_active) begin
			if (sel_restart) begin
				duty_active_buffer <= duty_write_byte; // [RL6]
				duty_latch <= channel_control_register[CTRL_LOW_LSB+:2]; // [RL13]
			end
		end else if (reg_write_in && reg_addr_in == OFS_DUTY_ACTIVE) begin
			duty_active_buffer <= reg_wdata_in; // [RL10]
		end
	end

	// ----------------------------------------
	// Output pin
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pwm_output_pin_out <= 1'b0; // [RL18]
		end else if (!pwm_active) begin
			pwm_output_pin_out <= 1'b0; // [RL14]
		end else if (sel_restart) begin
			pwm_output_pin_out <= duty_next != '0; // [RL5]
		end else if (time_base == duty_now || (sel_step && base_ahead == duty_now)) begin
			pwm_output_pin_out <= 1'b0; // [RL11] [RL12]
		end
	end

	// Driver enabled only in PWM mode with direction cleared
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pwm_output_pin_oe_out <= 1'b0;
		end else begin
			pwm_output_pin_oe_out <= pwm_active && !pin_direction_bit; // [RL14] [RL15]
		end
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------
	logic [STAT_W-1:0] events;
	logic [STAT_W-1:0] clear;

	assign events = {pwm_active && sel_restart, tmr_flag};
	assign clear = (reg_write_in && reg_addr_in == OFS_STATUS) ? reg_wdata_in[STAT_W-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status <= '0;
		end else begin
			status <= (status & ~clear) | events;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status & mask);
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = '0;
		if (reg_addr_in == OFS_CONTROL) begin
			next_rdata = channel_control_register;
		end else if (reg_addr_in == OFS_DUTY_WRITE) begin
			next_rdata = duty_write_byte;
		end else if (reg_addr_in == OFS_DUTY_ACTIVE) begin
			next_rdata = duty_active_buffer;
		end else if (reg_addr_in == OFS_TIMER_SELECT) begin
			next_rdata = {6'h00, timer_source_select};
		end else if (reg_addr_in == OFS_PIN_DIR) begin
			next_rdata = {7'h00, pin_direction_bit};
		end else if (reg_addr_in == OFS_STATUS) begin
			next_rdata = {4'h0, status};
		end else if (reg_addr_in == OFS_MASK) begin
			next_rdata = {4'h0, mask};
		end else if (in_timer_window(reg_addr_in) && timer_index < 2'(TIMER_N)) begin
			if (timer_field == TREG_CONTROL) begin
				next_rdata = {1'b0, timer_control_register[timer_index]};
			end else if (timer_field == TREG_PERIOD) begin
				next_rdata = period_limit[timer_index];
			end else if (timer_field == TREG_COUNT) begin
				next_rdata = tmr_count[timer_index];
			end
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= '0;
		end else begin
			reg_rdata_out <= reg_read_in ? next_rdata : '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_period_start_high: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL5]
		pwm_active && sel_restart && duty_next != '0 |=> pwm_output_pin_out)
		else $error("pin not set at period start");
	a_zero_duty_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL5]
		pwm_active && sel_restart && duty_next == '0 |=> !pwm_output_pin_out)
		else $error("pin set with zero duty");
	a_duty_copy_taken: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL6]
		pwm_active && sel_restart |=> duty_now == $past(duty_next))
		else $error("duty not copied at period start");
	a_active_read_only: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL10]
		pwm_active && !sel_restart |=> $stable(duty_now))
		else $error("active duty changed mid period");
	a_match_clears_pin: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL12]
		pwm_active && !sel_restart && time_base == duty_now |=> !pwm_output_pin_out)
		else $error("pin not cleared on duty match");
	a_release_on_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL14]
		reg_write_in && reg_addr_in == OFS_CONTROL && reg_wdata_in == 8'h00
		|=> ##1 !pwm_output_pin_oe_out && !pwm_output_pin_out)
		else $error("pin not released after control cleared");
	a_rise_at_restart: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL11]
		$rose(pwm_output_pin_out) |-> $past(sel_restart) && $past(pwm_active))
		else $error("pin rose outside period start");
	a_idle_pin_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RL18]
		!pwm_active |=> !pwm_output_pin_out)
		else $error("pin high while PWM mode off");
	a_irq_follows: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(status & mask) != '0 |=> irq_out)
		else $error("interrupt missing for unmasked status");
endmodule : standard_pwm_channel

// ==== sim/pwm_load_model.sv ====
`timescale 1ns/10ps
module pwm_load_model (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic pin_in,
	input wire logic pin_oe_in,
	output logic [15:0] high_cycles_out,
	output logic [15:0] period_cycles_out,
	output logic [15:0] rises_out
);
	logic level;
	logic prev;
	logic [15:0] since;
	logic [15:0] high_run;
	// Pull-down holds an undriven line low
	assign level = pin_oe_in ? pin_in : 1'h0;
	// ----------------------------------------
	// Pulse and period measurement
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prev <= 1'h0;
			since <= 16'h0000;
			high_run <= 16'h0000;
			high_cycles_out <= 16'h0000;
			period_cycles_out <= 16'h0000;
			rises_out <= 16'h0000;
		end else begin
			prev <= level;
			if (level && !prev) begin
				period_cycles_out <= since;
				since <= 16'h0001;
				high_run <= 16'h0001;
				rises_out <= rises_out + 16'h0001;
			end else begin
				since <= since + 16'h0001;
				if (level) begin
					high_run <= high_run + 16'h0001;
				end
			end
			if (!level && prev) begin
				high_cycles_out <= high_run;
			end
		end
	end
endmodule : pwm_load_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
module tb_top import pwm_pkg::*; ;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [ADDR_W-1:0] addr = 5'h00;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic wr_en = 1'h0;
	logic rd_en = 1'h0;
	logic [DATA_W-1:0] rdata;
	logic pin;
	logic pin_oe;
	logic irq;
	logic [15:0] high_cycles;
	logic [15:0] period_cycles;
	logic [15:0] pulses;
	int err_count = 0;
	int n_tests = 0;
	int p;
	int duty;
	int k;
	int snap;
	logic [4:0] rst_addr [0:7] = '{OFS_CONTROL, OFS_DUTY_WRITE, OFS_DUTY_ACTIVE, OFS_TIMER_SELECT,
		OFS_PIN_DIR, OFS_STATUS, OFS_MASK, 5'h07};
	logic [7:0] rst_val [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
	int sel_period [0:3] = '{8, 16, 32, 8};

	initial begin
		forever #2.5 clk = ~clk;
	end

	standard_pwm_channel standard_pwm_channel_inst (.mclk_in(clk), .reset_n_in(reset_n), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
		.pwm_output_pin_out(pin), .pwm_output_pin_oe_out(pin_oe), .irq_out(irq));
	pwm_load_model pwm_load_model_inst (.clk_in(clk), .reset_n_in(reset_n), .pin_in(pin), .pin_oe_in(pin_oe),
		.high_cycles_out(high_cycles), .period_cycles_out(period_cycles), .rises_out(pulses));

	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic hang();
		err_count++;
		$display("BAD t=%0t wait timed out", $time);
		summarize();
	endtask : hang

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1;
		d = rdata;
	endtask : rd

	task automatic rchk(input logic [4:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		rd(a, d);
		chk(16'(d), 16'(exp), what);
	endtask : rchk

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// Waits for n new pulses, then for the end of the last one
	task automatic wait_rises(input int n);
		int start;
		int t;
		start = pulses;
		t = 0;
		while (int'(pulses) - start < n || pin !== 1'h0) begin
			settle(1);
			t++;
			if (t > 20000)
				hang();
		end
		settle(2);
	endtask : wait_rises

	task automatic poll_status(input int b);
		logic [7:0] d;
		int t;
		d = 8'h00;
		for (t = 0; t < 200 && d[b] !== 1'h1; t++)
			rd(OFS_STATUS, d);
		if (d[b] !== 1'h1)
			hang();
	endtask : poll_status

	function automatic logic [4:0] taddr(input int n, input logic [1:0] r);
		return OFS_TIMER_BASE + 5'(4 * n) + {3'h0, r};
	endfunction : taddr

	function automatic logic [7:0] ctl(input logic [1:0] low);
		return {2'h0, low, PWM_MODE_CODE, 2'h0};
	endfunction : ctl

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		settle(1);
		chk(16'(pin), 16'h0000, "pin after reset");
		chk(16'(pin_oe), 16'h0000, "driver after reset");
		for (int i = 0; i < 8; i++)
			rchk(rst_addr[i], rst_val[i], "reset value");
		for (int n = 0; n < 3; n++) begin
			rchk(taddr(n, TREG_PERIOD), 8'hFF, "period reset");
			rchk(taddr(n, TREG_COUNT), 8'h00, "count reset");
			rchk(taddr(n, 2'h3), 8'h00, "unused timer slot");
		end
		wr(5'h07, 8'h5A);
		rchk(5'h07, 8'h00, "unmapped write");
		// Setup order: driver off, select, period, mode, duty, flag, run, wait, driver on
		wr(OFS_PIN_DIR, 8'h01);
		wr(OFS_TIMER_SELECT, 8'h01);
		wr(taddr(1, TREG_PERIOD), 8'h03);
		wr(OFS_CONTROL, ctl(2'h0));
		wr(OFS_DUTY_WRITE, 8'h01);
		wr(OFS_STATUS, 8'h0F);
		wr(taddr(1, TREG_CONTROL), 8'h04);
		poll_status(1);
		wr(OFS_PIN_DIR, 8'h00);
		settle(2);
		chk(16'(pin_oe), 16'h0001, "driver enabled");
		// Every prescale code, postscale varied
		for (int c = 0; c < 4; c++) begin
			p = (c == 0) ? 1 : (c == 1) ? 4 : 16;
			duty = 5 + 3 * c;
			wr(OFS_DUTY_WRITE, 8'(duty >> 2));
			wr(OFS_CONTROL, ctl(2'(duty)));
			wr(taddr(1, TREG_CONTROL), 8'(4 + c + 40 * c));
			wait_rises(3);
			chk(period_cycles, 16'(16 * p), "period");
			chk(high_cycles, 16'(duty * p), "high time");
		end
		// Duty byte 3 active; new value waits for the next restart
		wait_rises(1);
		wr(OFS_DUTY_WRITE, 8'h02);
		rchk(OFS_DUTY_ACTIVE, 8'h03, "active before restart");
		wr(OFS_DUTY_ACTIVE, 8'hAA);
		rchk(OFS_DUTY_ACTIVE, 8'h03, "active is read only");
		wait_rises(1);
		rchk(OFS_DUTY_ACTIVE, 8'h02, "active after restart");
		chk(high_cycles, 16'd160, "latched high time");
		// Zero duty keeps the pin low
		wr(OFS_DUTY_WRITE, 8'h00);
		wr(OFS_CONTROL, ctl(2'h0));
		wr(taddr(1, TREG_CONTROL), 8'h04);
		settle(300);
		snap = pulses;
		settle(64);
		chk(16'(int'(pulses) - snap), 16'h0000, "zero duty pulses");
		chk(16'(pin), 16'h0000, "zero duty level");
		wr(OFS_DUTY_WRITE, 8'hFF);
		settle(40);
		chk(16'(pin), 16'h0001, "duty past period");
		// Each timer source
		wr(OFS_DUTY_WRITE, 8'h01);
		wr(taddr(0, TREG_PERIOD), 8'h01);
		wr(taddr(2, TREG_PERIOD), 8'h07);
		wr(taddr(0, TREG_CONTROL), 8'h04);
		wr(taddr(2, TREG_CONTROL), 8'h04);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_TIMER_SELECT, 8'(s));
			wait_rises(3);
			chk(period_cycles, 16'(sel_period[s]), "selected timer period");
		end
		wr(OFS_CONTROL, 8'h00);
		settle(2);
		chk(16'(pin_oe), 16'h0000, "released driver");
		chk(16'(pin), 16'h0000, "released level");
		// Interrupt: raise, mask, clear
		wr(OFS_MASK, 8'h02);
		for (k = 0; k < 100 && irq !== 1'h1; k++)
			settle(1);
		chk(16'(irq), 16'h0001, "irq raised");
		wr(OFS_MASK, 8'h00);
		settle(2);
		chk(16'(irq), 16'h0000, "irq masked");
		for (int n = 0; n < 3; n++)
			wr(taddr(n, TREG_CONTROL), 8'h00);
		rchk(OFS_STATUS, 8'h0F, "events latched");
		wr(taddr(0, TREG_COUNT), 8'h2A);
		rchk(taddr(0, TREG_COUNT), 8'h2A, "count load");
		wr(OFS_STATUS, 8'h0F);
		rchk(OFS_STATUS, 8'h00, "status cleared");
		wr(OFS_MASK, 8'h02);
		settle(2);
		chk(16'(irq), 16'h0000, "irq after clear");
		summarize();
	end
endmodule : tb_top
